// File: hw/hpp_pkg.sv
package hpp_pkg;

    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned REG_COUNT     = 16;
    localparam int unsigned INDEX_W       = 4;
    localparam int unsigned DATA_W        = 8;

    localparam logic [3:0] STATUS0_IDX    = 4'h0;
    localparam logic [3:0] STATUS1_IDX    = 4'h1;
    localparam logic [3:0] MASK0_IDX      = 4'h2;
    localparam logic [3:0] MASK1_IDX      = 4'h3;
    localparam logic [3:0] MASK_ALL_IDX   = 4'h4;
    localparam int unsigned MASK_ALL_BIT  = 0;

    localparam int unsigned DEV_SEL_BIT   = 3;
    localparam int unsigned DEV_ID_LSB    = 4;
    localparam int unsigned DEV_ID_W      = 3;

    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [3:0] INDEX_RESET    = 4'h0;

    localparam int unsigned PORT_CLK_MAX_PERIOD_NS = 323;
    localparam int unsigned PORT_CLK_MAX_PERIOD_CYC =
        (PORT_CLK_MAX_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] PORT_CLK_IDLE_LIMIT = 8'(2 * PORT_CLK_MAX_PERIOD_CYC);

    typedef enum logic [1:0] {
        HPP_IDLE,
        HPP_WAIT,
        HPP_DONE
    } hpp_stage_e;

endpackage

// File: hw/hpp_index_latch.sv
`timescale 1ns/1ps
`default_nettype none

module hpp_index_latch (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       clear,
    input  wire logic       index_capture_strobe,
    input  wire logic       bus_sharing_select,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] data_in,
    output logic      [3:0] index,
    output logic            id_match
);

    typedef struct packed {
        logic       strobe_prev;
        logic [3:0] index;
        logic [2:0] dev_id;
    } hpp_latch_s;

    hpp_latch_s state_reg;
    hpp_latch_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.strobe_prev = index_capture_strobe;
        if (clear) begin
            state_next.index  = hpp_pkg::INDEX_RESET;
            state_next.dev_id = '0;
        end else if (state_reg.strobe_prev && !index_capture_strobe) begin
            if (bus_sharing_select) begin
                state_next.index  = data_in[3:0];
                state_next.dev_id = data_in[hpp_pkg::DEV_ID_LSB +: hpp_pkg::DEV_ID_W];
            end else begin
                state_next.index  = addr_in;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= '{strobe_prev: 1'b1, index: hpp_pkg::INDEX_RESET, dev_id: 3'h0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign index    = state_reg.index;
    // device number compare against the strap inputs
    assign id_match = (state_reg.dev_id == addr_in[2:0]);

endmodule

`default_nettype wire

// File: hw/hpp_host_port.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - protocol strap picks strobe style
// - multiplex strap shares address and data lines
// - data strobe low with write stores data
// - index captured on capture strobe falling edge
// - port answers only with chip select low
// - unmasked alarm status raises interrupt output
// - latch-enable style: done flag goes high
// - done flag floats while chip unselected
// - strobe style: done flag goes low
// - multiplexed: low four bits pick register
// - separate bus: dedicated address picks register
// - internal select matches latched device number
// - hardware reset low clears port state
// - interrupt released after reading alarm status
// - one wait cycle stretches each access

module hpp_host_port (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic         hw_reset_n,
    input  wire logic         host_protocol_select,
    input  wire logic         bus_sharing_select,
    input  wire logic         chip_select_n,
    input  wire logic         store_or_data_strobe_n,
    input  wire logic         fetch_or_direction,
    input  wire logic         index_capture_strobe,
    input  wire logic [3:0]   addr_in,
    input  wire logic [7:0]   data_in,
    input  wire logic         host_port_clock,
    input  wire logic [7:0]   alarm_set0,
    input  wire logic [7:0]   alarm_set1,
    output logic      [7:0]   data_out,
    output logic              data_oe,
    output logic              transfer_done_flag,
    output logic              transfer_done_oe,
    output logic              alarm_irq,
    output logic      [127:0] reg_image
);

    typedef struct packed {
        logic [15:0][7:0]   regs;
        hpp_pkg::hpp_stage_e stage;
        logic [3:0]         acc_index;
        logic [7:0]         rdata;
        logic               data_oe;
        logic               done_flag;
        logic               done_oe;
        logic               irq;
        logic               pclk_prev;
        logic [7:0]         pclk_idle_cnt;
    } hpp_port_s;

    hpp_port_s state_reg;
    hpp_port_s state_next;

    logic [3:0] index;
    logic       id_match;

    ////////////////////////////////////////////////////////////////////////////
    // index capture and device number

    hpp_index_latch u_index_latch (
        .core_clk             (core_clk),
        .reset                (reset),
        .clear                (!hw_reset_n),
        .index_capture_strobe (index_capture_strobe),
        .bus_sharing_select   (bus_sharing_select),
        .addr_in              (addr_in),
        .data_in              (data_in),
        .index                (index),
        .id_match             (id_match)
    );

    ////////////////////////////////////////////////////////////////////////////
    // access decode and register file

    logic       internal_sel;
    logic       selected;
    logic       rd_act;
    logic       wr_act;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic       irq_raw;
    logic       pclk_rise;
    logic       out_update;
    logic       done_now;

    always_comb begin
        state_next = state_reg;
        clr0 = 8'h00;
        clr1 = 8'h00;

        internal_sel = bus_sharing_select && addr_in[hpp_pkg::DEV_SEL_BIT];
        selected = !chip_select_n && (!internal_sel || id_match);

        if (host_protocol_select) begin
            rd_act = !fetch_or_direction;
            wr_act = !store_or_data_strobe_n;
        end else begin
            rd_act = !store_or_data_strobe_n && fetch_or_direction;
            wr_act = !store_or_data_strobe_n && !fetch_or_direction;
        end

        unique case (state_reg.stage)
            hpp_pkg::HPP_IDLE: begin
                if (selected && (rd_act || wr_act)) begin
                    state_next.stage = hpp_pkg::HPP_WAIT;
                    state_next.acc_index = index;
                    if (wr_act && index != hpp_pkg::STATUS0_IDX && index != hpp_pkg::STATUS1_IDX) begin
                        state_next.regs[index] = data_in;
                    end
                    if (rd_act) begin
                        state_next.rdata = state_reg.regs[index];
                        if (index == hpp_pkg::STATUS0_IDX) begin
                            clr0 = state_reg.regs[hpp_pkg::STATUS0_IDX];
                        end
                        if (index == hpp_pkg::STATUS1_IDX) begin
                            clr1 = state_reg.regs[hpp_pkg::STATUS1_IDX];
                        end
                    end
                end
            end
            hpp_pkg::HPP_WAIT: begin
                state_next.stage = hpp_pkg::HPP_DONE;
            end
            hpp_pkg::HPP_DONE: begin
                if (!selected || !(rd_act || wr_act)) begin
                    state_next.stage = hpp_pkg::HPP_IDLE;
                end
            end
        endcase

        // read drive only while selected and reading
        state_next.data_oe = selected && rd_act && (state_reg.stage != hpp_pkg::HPP_IDLE);

        // sticky alarms: a new event wins over the read clear
        state_next.regs[hpp_pkg::STATUS0_IDX] =
            (state_reg.regs[hpp_pkg::STATUS0_IDX] & ~clr0) | alarm_set0;
        state_next.regs[hpp_pkg::STATUS1_IDX] =
            (state_reg.regs[hpp_pkg::STATUS1_IDX] & ~clr1) | alarm_set1;

        irq_raw = ((|(state_reg.regs[hpp_pkg::STATUS0_IDX] & ~state_reg.regs[hpp_pkg::MASK0_IDX]))
                  || (|(state_reg.regs[hpp_pkg::STATUS1_IDX] & ~state_reg.regs[hpp_pkg::MASK1_IDX])))
                  && !state_reg.regs[hpp_pkg::MASK_ALL_IDX][hpp_pkg::MASK_ALL_BIT];

        // port clock: follow its rising edge when running, else update freely
        state_next.pclk_prev = host_port_clock;
        pclk_rise = host_port_clock && !state_reg.pclk_prev;
        if (pclk_rise) begin
            state_next.pclk_idle_cnt = 8'h00;
        end else if (state_reg.pclk_idle_cnt != hpp_pkg::PORT_CLK_IDLE_LIMIT) begin
            state_next.pclk_idle_cnt = state_reg.pclk_idle_cnt + 8'h01;
        end
        out_update = pclk_rise || (state_reg.pclk_idle_cnt == hpp_pkg::PORT_CLK_IDLE_LIMIT);

        done_now = (state_reg.stage == hpp_pkg::HPP_DONE);
        if (out_update) begin
            state_next.irq = irq_raw;
            state_next.done_flag = host_protocol_select ? done_now : !done_now;
        end
        state_next.done_oe = !chip_select_n;

        if (!hw_reset_n) begin
            state_next.regs = {hpp_pkg::REG_COUNT{hpp_pkg::REG_RESET}};
            state_next.stage = hpp_pkg::HPP_IDLE;
            state_next.data_oe = 1'b0;
            state_next.irq = 1'b0;
            state_next.done_flag = !host_protocol_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= '{regs: {hpp_pkg::REG_COUNT{hpp_pkg::REG_RESET}},
                           stage: hpp_pkg::HPP_IDLE,
                           acc_index: hpp_pkg::INDEX_RESET,
                           rdata: 8'h00,
                           data_oe: 1'b0,
                           done_flag: 1'b0,
                           done_oe: 1'b0,
                           irq: 1'b0,
                           pclk_prev: 1'b0,
                           pclk_idle_cnt: 8'h00};
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign data_out           = state_reg.rdata;
    assign data_oe            = state_reg.data_oe;
    assign transfer_done_flag = state_reg.done_flag;
    assign transfer_done_oe   = state_reg.done_oe;
    assign alarm_irq          = state_reg.irq;
    assign reg_image          = state_reg.regs;

endmodule

`default_nettype wire

// File: tb/hpp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hpp_chk (
    input wire logic         core_clk,
    input wire logic         reset,
    input wire logic         hw_reset_n,
    input wire logic         host_protocol_select,
    input wire logic         chip_select_n,
    input wire logic         store_or_data_strobe_n,
    input wire logic         fetch_or_direction,
    input wire logic [7:0]   alarm_set0,
    input wire logic         data_oe,
    input wire logic         transfer_done_flag,
    input wire logic         transfer_done_oe,
    input wire logic         alarm_irq,
    input wire logic [127:0] reg_image
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire       p = host_protocol_select;
    wire       s = !store_or_data_strobe_n;
    wire       rd_on = !chip_select_n && (p ? !fetch_or_direction : fetch_or_direction && s);
    wire [7:0] live = reg_image[7:0] & ~reg_image[23:16] | reg_image[15:8] & ~reg_image[31:24];
    chk_done_unsel: assert property (chip_select_n [*2] |-> !transfer_done_oe) else $error("flag driven");
    chk_read_gated: assert property (data_oe |-> $past(rd_on)) else $error("read drive");
    chk_ready_high: assert property (p && $rose(transfer_done_flag) |-> (s || !fetch_or_direction)
        && $past(s || !fetch_or_direction, 2)) else $error("ready early");
    chk_ack_low: assert property (!p && $fell(transfer_done_flag) |-> !chip_select_n && s && $past(s, 2))
        else $error("ack early");
    chk_irq_cause: assert property (alarm_irq |-> (live | $past(live)) != 8'h00
        && !(reg_image[32] && $past(reg_image[32]))) else $error("irq cause");
    chk_status_set: assert property ((reg_image[7:0] & ~$past(reg_image[7:0]) & ~$past(alarm_set0)
        & ~$past(alarm_set0, 2)) == 8'h00) else $error("status set");
    chk_hw_clear: assert property (!hw_reset_n |=> reg_image == 128'h0 && !alarm_irq && !data_oe)
        else $error("hw reset");
    chk_write_sel: assert property ($changed(reg_image[127:16]) |-> !$past(chip_select_n) || !$past(hw_reset_n))
        else $error("write unselected");
    cover property (p && $rose(transfer_done_flag));
    cover property (!p && $fell(transfer_done_flag));
    cover property ($rose(alarm_irq));
endmodule
bind hpp_host_port hpp_chk chk (.core_clk, .reset, .hw_reset_n, .host_protocol_select, .chip_select_n,
    .store_or_data_strobe_n, .fetch_or_direction, .alarm_set0, .data_oe, .transfer_done_flag,
    .transfer_done_oe, .alarm_irq, .reg_image);
`default_nettype wire

// File: tb/hpp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hpp_host_model (
    input  wire logic       core_clk,
    input  wire logic       host_protocol_select,
    input  wire logic       bus_sharing_select,
    input  wire logic       transfer_done_flag,
    input  wire logic [7:0] data_out,
    output logic            chip_select_n = 1'b1,
    output logic            store_or_data_strobe_n = 1'b1,
    output logic            fetch_or_direction = 1'b1,
    output logic            index_capture_strobe = 1'b0,
    output logic      [3:0] addr_in = 4'h0,
    output logic      [7:0] data_in = 8'h00
);
    task automatic access(input logic wr, input logic [7:0] ad, input logic [7:0] wd, input logic [3:0] pins,
                          input int bound, output logic [7:0] rd, output logic ok);
        ok = 1'b0;
        rd = 8'h00;
        @(posedge core_clk);
        index_capture_strobe <= 1'b1;
        addr_in <= bus_sharing_select ? pins : ad[3:0];
        data_in <= ad;
        @(posedge core_clk);
        index_capture_strobe <= 1'b0;
        repeat (2) @(posedge core_clk);
        chip_select_n <= 1'b0;
        data_in <= wr ? wd : ~ad;
        store_or_data_strobe_n <= !wr && host_protocol_select;
        fetch_or_direction <= host_protocol_select ? wr : !wr;
        for (int n = 0; n < bound && !ok; n++) begin
            @(posedge core_clk);
            ok = transfer_done_flag === host_protocol_select;
            rd = data_out;
        end
        chip_select_n <= 1'b1;
        store_or_data_strobe_n <= 1'b1;
        fetch_or_direction <= host_protocol_select;
        data_in <= ~data_in;
        for (int n = 0; n < bound && transfer_done_flag === host_protocol_select; n++) begin
            @(posedge core_clk);
        end
        @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic            core_clk = 1'b0;
    logic            reset = 1'b1;
    logic            hw_reset_n = 1'b1;
    logic            host_protocol_select = 1'b1;
    logic            bus_sharing_select = 1'b0;
    logic [7:0]      alarm_set0 = 8'h00;
    logic [7:0]      alarm_set1 = 8'h00;
    logic            host_port_clock = 1'b0;
    logic            pclk_run = 1'b0;
    logic [3:0]      pclk_div = 4'h0;
    wire logic       chip_select_n, store_or_data_strobe_n, fetch_or_direction, index_capture_strobe;
    wire logic [3:0] addr_in;
    wire logic [7:0] data_in;
    logic [7:0]      data_out, rd;
    logic            data_oe, transfer_done_flag, transfer_done_oe, alarm_irq;
    logic [127:0]    reg_image;
    int              failures = 0;
    int              comparisons = 0;
    always #2.5 core_clk = ~core_clk;
    // port clock of 16 core cycles (80 ns) while enabled
    always @(posedge core_clk) begin
        if (pclk_run) begin
            pclk_div <= pclk_div + 4'h1;
            host_port_clock <= pclk_div[3];
        end
    end
    hpp_host_port dut (.core_clk, .reset, .hw_reset_n, .host_protocol_select, .bus_sharing_select,
        .chip_select_n, .store_or_data_strobe_n, .fetch_or_direction, .index_capture_strobe, .addr_in,
        .data_in, .host_port_clock, .alarm_set0, .alarm_set1, .data_out, .data_oe,
        .transfer_done_flag, .transfer_done_oe, .alarm_irq, .reg_image);
    hpp_host_model host (.core_clk, .host_protocol_select, .bus_sharing_select, .transfer_done_flag,
        .data_out, .chip_select_n, .store_or_data_strobe_n, .fetch_or_direction, .index_capture_strobe,
        .addr_in, .data_in);
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] ad, input logic [7:0] wd, input logic [3:0] pins,
                       input logic exp_ok);
        logic ok;
        host.access(wr, ad, wd, pins, exp_ok ? 400 : 20, rd, ok);
        check({7'h00, ok}, {7'h00, exp_ok});
        if (ok !== exp_ok) finish_test();
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            host_protocol_select <= !m[1];
            bus_sharing_select <= m[0];
            repeat (4) @(posedge core_clk);
            acc(1'b1, 8'hF5 + 8'(m), 8'hA0 + 8'(m), 4'h0, 1'b1);
            check(reg_image[8 * (5 + m) +: 8], 8'hA0 + 8'(m));
            acc(1'b0, 8'hF5 + 8'(m), 8'h00, 4'h0, 1'b1);
            check(rd, 8'hA0 + 8'(m));
        end
        $display("modes test done");
    endtask
    task automatic t_irq();
        acc(1'b1, 8'h00, 8'hFF, 4'h0, 1'b1);
        check(reg_image[7:0], 8'h00);
        alarm_set0 <= 8'h04;
        @(posedge core_clk);
        alarm_set0 <= 8'h00;
        repeat (4) @(posedge core_clk);
        check({7'h00, alarm_irq}, 8'h01);
        acc(1'b0, 8'h00, 8'h00, 4'h0, 1'b1);
        check(rd, 8'h04);
        repeat (2) @(posedge core_clk);
        check({7'h00, alarm_irq}, 8'h00);
        acc(1'b1, 8'h02, 8'h04, 4'h0, 1'b1);
        acc(1'b1, 8'h04, 8'h01, 4'h0, 1'b1);
        alarm_set0 <= 8'h04;
        alarm_set1 <= 8'h01;
        @(posedge core_clk);
        alarm_set0 <= 8'h00;
        alarm_set1 <= 8'h00;
        repeat (4) @(posedge core_clk);
        check({7'h00, alarm_irq}, 8'h00);
        acc(1'b1, 8'h04, 8'h00, 4'h0, 1'b1);
        repeat (2) @(posedge core_clk);
        check({7'h00, alarm_irq}, 8'h01);
        acc(1'b0, 8'h01, 8'h00, 4'h0, 1'b1);
        check(rd, 8'h01);
        acc(1'b0, 8'h00, 8'h00, 4'h0, 1'b1);
        check(rd, 8'h04);
        check({7'h00, alarm_irq}, 8'h00);
        $display("alarm test done");
    endtask
    task automatic t_isel();
        acc(1'b1, 8'h5A, 8'h66, 4'hD, 1'b1);
        acc(1'b1, 8'h3A, 8'h99, 4'hD, 1'b0);
        check(reg_image[87:80], 8'h66);
        $display("select test done");
    endtask
    task automatic t_hwrst();
        hw_reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        hw_reset_n <= 1'b1;
        @(posedge core_clk);
        check({7'h00, |reg_image}, 8'h00);
        acc(1'b0, 8'h05, 8'h00, 4'h0, 1'b1);
        check(rd, 8'h00);
        $display("hardware reset test done");
    endtask
    task automatic t_pclk();
        pclk_run <= 1'b1;
        repeat (40) @(posedge core_clk);
        acc(1'b1, 8'h0B, 8'h3C, 4'h0, 1'b1);
        acc(1'b0, 8'h0B, 8'h00, 4'h0, 1'b1);
        check(rd, 8'h3C);
        check({6'h00, data_oe, transfer_done_oe}, 8'h00);
        $display("port clock test done");
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        t_modes();
        t_irq();
        t_isel();
        t_hwrst();
        t_pclk();
        finish_test();
    end
endmodule
`default_nettype wire
